// File: hw/irr_pkg.sv
// Constants and carrier types for the infrared remote command decoder
package irr_pkg;

  // Clock and internal oscillator tick
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned OSC_HZ     = 38_000;
  localparam int unsigned OSC_DIV    = CLK_HZ / OSC_HZ;

  // Output pulse times, in ms and in oscillator ticks
  localparam int unsigned SHOT_MS    = 107;
  localparam int unsigned HOLD_MS    = 160;
  localparam int unsigned SHOT_TICKS = SHOT_MS * OSC_HZ / 1000;
  localparam int unsigned HOLD_TICKS = HOLD_MS * OSC_HZ / 1000;
  localparam int unsigned TMR_W      = 13;

  // Line framing, in oscillator ticks
  localparam int unsigned BIT_TICKS  = 16;
  localparam int unsigned HALF_TICKS = BIT_TICKS / 2;
  localparam int unsigned GAP_TICKS  = 64;
  localparam int unsigned BTMR_W     = 8;

  // Frame layout, sent first bit at the top
  localparam int unsigned FRAME_W    = 12;
  localparam int unsigned POS_CODE1  = 11;
  localparam int unsigned POS_CODE2  = 10;
  localparam int unsigned POS_CODE3  = 9;
  localparam int unsigned POS_HOLD   = 8;
  localparam int unsigned POS_GRPA   = 7;
  localparam int unsigned POS_GRPB   = 6;
  localparam int unsigned POS_KEY1   = 5;
  localparam int unsigned NKEY       = 6;
  localparam int unsigned NHOLD      = 6;
  localparam int unsigned NSHOT      = 10;
  localparam int unsigned NFLIP      = 2;
  localparam int unsigned NSMALL     = 5;

  // Register map, byte addresses
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_FRAME   = 4'h8;
  localparam int unsigned CTRL_CODEA = 0;
  localparam int unsigned CTRL_CODEB = 1;
  localparam int unsigned CTRL_SMALL = 2;
  localparam logic [2:0] CTRL_RST    = 3'h3;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } irr_av_req_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } irr_rx_state_t;

endpackage

// File: hw/irr_decoder.sv
// Infrared remote command decoder with Avalon-MM control registers
//
// Summary of operation
// RULE1: Accept only two identical successive frames.
// RULE2: Store first frame in 12-bit register.
// RULE3: Second frame shifts stored bits, compares each.
// RULE4: Any mismatch resets reception, discards frame.
// RULE5: All twelve match lets output rise.
// RULE6: Sample each bit at mid period.
// RULE7: Latch pulse only when code bits match.
// RULE8: Code mismatch: no latch, outputs stay low.
// RULE9: Host must not set both code bits zero.
// RULE10: Unpinned code bit fixed one, per variant.
// RULE11: Transmitter sends one in fixed bit.
// RULE12: One-shot output high about 107 ms.
// RULE13: Hold output rises on first latch pulse.
// RULE14: Hold output drops 160 ms after repeats stop.
// RULE15: Up to six hold outputs at once.
// RULE16: Toggle command inverts its toggle output.
// RULE17: Frame: three code bits, nine data bits.
// RULE18: Map group flags and keys to outputs.
// RULE19: Small variant: only ten commands accepted.
// RULE20: Initialise internal state at reset.
// RULE21: All timing from 38 kHz oscillator tick.
// RULE22: Front end delivers demodulated baseband only.
// RULE23: Synchronise input; repeats restart hold timer.
`timescale 1ns/10ps
`default_nettype none

module irr_decoder
  import irr_pkg::*;
#(
  parameter int unsigned OSC_DIV_P    = irr_pkg::OSC_DIV,
  parameter int unsigned SHOT_TICKS_P = irr_pkg::SHOT_TICKS,
  parameter int unsigned HOLD_TICKS_P = irr_pkg::HOLD_TICKS
) (
  // Clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // Demodulated receive line
  input  wire logic                 i_remote_rx_in,
  // Avalon-MM slave
  input  wire irr_pkg::irr_av_req_t i_av,
  output logic [31:0]               o_av_readdata,
  output logic                      o_av_waitrequest,
  // Command outputs
  output logic [irr_pkg::NHOLD-1:0] o_hold_outputs,
  output logic [irr_pkg::NSHOT-1:0] o_oneshot_outputs,
  output logic [irr_pkg::NFLIP-1:0] o_flip_outputs
);
  import irr_pkg::*;

  // Oscillator tick
  logic [15:0]         osc_cnt_r;
  logic                tick_r;
  // Receive path
  logic                rx_meta_r;
  logic                rx_sync_r;
  irr_rx_state_t       rx_state_r;
  logic [BTMR_W-1:0]   btmr_r;
  logic [3:0]          bit_cnt_r;
  logic [FRAME_W-1:0]  store_r;
  logic                second_r;
  logic [BTMR_W-1:0]   gap_r;
  logic                latch_r;
  logic [FRAME_W-1:0]  last_frame_r;
  // Registers
  logic [2:0]          ctrl_r;
  logic                wait_r;
  logic [31:0]         rdata_r;

  wire logic bit_due  = tick_r && (btmr_r == '0);
  wire logic av_req   = i_av.read || i_av.write;
  wire logic av_fire  = av_req && !wait_r;
  wire logic small_v  = ctrl_r[CTRL_SMALL];

  // Oscillator tick divider
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      osc_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else if (osc_cnt_r == 16'(OSC_DIV_P - 1)) begin
      osc_cnt_r <= 16'h0000;
      tick_r    <= 1'b1; // [RULE21]
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
      tick_r    <= 1'b0;
    end
  end

  // Input synchroniser; line already stripped of carrier upstream
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
    end else begin
      rx_meta_r <= i_remote_rx_in; // [RULE23] [RULE22]
      rx_sync_r <= rx_meta_r;
    end
  end

  // Expected code bits, one of them fixed high by variant
  logic [2:0] exp_code;
  always_comb begin
    if (small_v) begin
      exp_code = {1'b1, ctrl_r[CTRL_CODEA], ctrl_r[CTRL_CODEB]}; // [RULE10]
    end else begin
      exp_code = {ctrl_r[CTRL_CODEA], ctrl_r[CTRL_CODEB], 1'b1}; // [RULE10]
    end
  end

  // Taken one place down: the last bit is still on the line at the latch
  wire logic [2:0] rx_code = {store_r[POS_CODE1-1], store_r[POS_CODE2-1],
                              store_r[POS_CODE3-1]};

  // Frame receiver and two-copy check
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_state_r   <= RX_IDLE; // [RULE20]
      btmr_r       <= '0;
      bit_cnt_r    <= 4'h0;
      store_r      <= '0;
      second_r     <= 1'b0;
      gap_r        <= '0;
      latch_r      <= 1'b0;
      last_frame_r <= '0;
    end else begin
      latch_r <= 1'b0;
      if (tick_r && btmr_r != '0) begin
        btmr_r <= btmr_r - 1'b1;
      end
      unique case (rx_state_r)
        RX_IDLE: begin
          // Lone first copy expires if no second copy follows
          if (second_r && tick_r) begin
            if (gap_r == BTMR_W'(GAP_TICKS)) begin
              second_r <= 1'b0;
            end else begin
              gap_r <= gap_r + 1'b1;
            end
          end
          if (rx_sync_r) begin
            rx_state_r <= RX_START;
            btmr_r     <= BTMR_W'(HALF_TICKS); // [RULE6]
          end
        end
        RX_START: begin
          if (bit_due) begin
            if (rx_sync_r) begin
              rx_state_r <= RX_DATA;
              btmr_r     <= BTMR_W'(BIT_TICKS - 1); // [RULE6]
              bit_cnt_r  <= 4'h0;
            end else begin
              rx_state_r <= RX_IDLE; // Glitch, not a start bit
            end
          end
        end
        RX_DATA: begin
          if (bit_due) begin
            btmr_r    <= BTMR_W'(BIT_TICKS - 1);
            bit_cnt_r <= bit_cnt_r + 4'h1;
            store_r   <= {store_r[FRAME_W-2:0], rx_sync_r}; // [RULE2] [RULE3]
            if (second_r && store_r[FRAME_W-1] != rx_sync_r) begin
              rx_state_r <= RX_STOP; // [RULE4]
              second_r   <= 1'b0;
              store_r    <= '0;
            end else if (bit_cnt_r == 4'(FRAME_W - 1)) begin
              rx_state_r <= RX_STOP;
              gap_r      <= '0;
              if (!second_r) begin
                second_r <= 1'b1; // [RULE1]
              end else begin
                second_r <= 1'b0;
                // Code bits still sit one place below their frame positions here
                if (rx_code == exp_code) begin
                  latch_r      <= 1'b1; // [RULE5] [RULE7]
                  last_frame_r <= {store_r[FRAME_W-2:0], rx_sync_r};
                end // [RULE8]
              end
            end
          end
        end
        RX_STOP: begin
          if (!rx_sync_r) begin
            rx_state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Decode of the latched frame
  wire logic             grp_hold = last_frame_r[POS_HOLD]; // [RULE17]
  wire logic             grp_a    = last_frame_r[POS_GRPA];
  wire logic             grp_b    = last_frame_r[POS_GRPB];
  logic [NKEY-1:0]       key;
  logic [NHOLD-1:0]      hold_hit;
  logic [NSHOT-1:0]      shot_hit;
  logic [NFLIP-1:0]      flip_hit;

  always_comb begin
    for (int k = 0; k < NKEY; k++) begin
      key[k] = last_frame_r[POS_KEY1 - k];
    end
    hold_hit = '0;
    shot_hit = '0;
    flip_hit = '0;
    if (latch_r) begin
      // Several hold keys may be pressed together
      if (grp_hold && !grp_a && !grp_b) begin
        hold_hit = key; // [RULE15] [RULE18]
      end else if (grp_a && !grp_hold && !grp_b) begin
        shot_hit[5:0] = key; // [RULE18]
      end else if (grp_b && !grp_hold && !grp_a && !small_v) begin
        shot_hit[9:6] = key[3:0]; // [RULE18] [RULE19]
        flip_hit      = key[5:4];
      end
      if (small_v) begin
        hold_hit[5]   = 1'b0; // [RULE19]
        shot_hit[5]   = 1'b0;
      end
    end
  end

  // Hold outputs with release timers
  genvar g;
  generate
    for (g = 0; g < NHOLD; g++) begin : g_hold
      logic [TMR_W-1:0] tmr_r;
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          tmr_r             <= '0;
          o_hold_outputs[g] <= 1'b0;
        end else if (hold_hit[g]) begin
          tmr_r             <= TMR_W'(HOLD_TICKS_P); // [RULE23] [RULE14]
          o_hold_outputs[g] <= 1'b1; // [RULE13]
        end else if (tick_r && tmr_r != '0) begin
          tmr_r <= tmr_r - 1'b1;
          if (tmr_r == TMR_W'(1)) begin
            o_hold_outputs[g] <= 1'b0; // [RULE14]
          end
        end
      end
    end
    for (g = 0; g < NSHOT; g++) begin : g_shot
      logic [TMR_W-1:0] tmr_r;
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          tmr_r                <= '0;
          o_oneshot_outputs[g] <= 1'b0;
        end else if (shot_hit[g]) begin
          tmr_r                <= TMR_W'(SHOT_TICKS_P); // [RULE12]
          o_oneshot_outputs[g] <= 1'b1;
        end else if (tick_r && tmr_r != '0) begin
          tmr_r <= tmr_r - 1'b1;
          if (tmr_r == TMR_W'(1)) begin
            o_oneshot_outputs[g] <= 1'b0; // [RULE12]
          end
        end
      end
    end
    for (g = 0; g < NFLIP; g++) begin : g_flip
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          o_flip_outputs[g] <= 1'b0;
        end else if (flip_hit[g]) begin
          o_flip_outputs[g] <= !o_flip_outputs[g]; // [RULE16]
        end
      end
    end
  endgenerate

  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !(av_req && wait_r);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_av.read && wait_r) begin
      unique case (i_av.address)
        OFS_CTRL:   rdata_r <= {29'h0, ctrl_r};
        OFS_STATUS: rdata_r <= {14'h0000, o_flip_outputs, o_oneshot_outputs,
                                o_hold_outputs};
        OFS_FRAME:  rdata_r <= {19'h0, second_r, last_frame_r};
        default:    rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Code bits held here; host keeps them off all-zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST; // [RULE20]
    end else if (av_fire && i_av.write && i_av.address == OFS_CTRL
                 && i_av.byteenable[0]) begin
      ctrl_r <= i_av.writedata[2:0]; // [RULE9]
    end
  end

  assign o_av_waitrequest = wait_r;
  assign o_av_readdata    = rdata_r;

endmodule

`default_nettype wire

// File: tb/irr_decoder_assertions.sv
// Port-level timing checks for the remote command decoder
`timescale 1ns/10ps
`default_nettype none
module irr_decoder_chk
  import irr_pkg::*;
#(
  parameter int unsigned OSC_DIV_P    = 4,
  parameter int unsigned SHOT_TICKS_P = 20,
  parameter int unsigned HOLD_TICKS_P = 30
) (
  // Watched ports
  input wire logic                      i_clock,
  input wire logic                      i_rst,
  input wire irr_pkg::irr_av_req_t      i_av,
  input wire logic [31:0]               o_av_readdata,
  input wire logic                      o_av_waitrequest,
  input wire logic [irr_pkg::NHOLD-1:0] o_hold_outputs,
  input wire logic [irr_pkg::NSHOT-1:0] o_oneshot_outputs,
  input wire logic [irr_pkg::NFLIP-1:0] o_flip_outputs
);
  // Tick phase is free running, so allow one tick plus sync slack
  localparam int SLO  = SHOT_TICKS_P * OSC_DIV_P - OSC_DIV_P - 2;
  localparam int HLO  = HOLD_TICKS_P * OSC_DIV_P - OSC_DIV_P - 2;
  localparam int SWIN = 2 * OSC_DIV_P + 4;
  logic req;
  logic wr;
  logic shot;
  logic hold;
  int   hcnt;
  assign req  = i_av.read | i_av.write;
  assign wr   = o_av_waitrequest;
  assign shot = |o_oneshot_outputs;
  assign hold = |o_hold_outputs;
  always_ff @(posedge i_clock) begin
    if (i_rst || !hold)
      hcnt <= 0;
    else
      hcnt <= hcnt + 1;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wait_one_a: assert property (req && wr |=> !wr)
    else $error("no answer after one wait cycle");
  wait_short_a: assert property (!wr |=> wr)
    else $error("wait low too long");
  wait_cause_a: assert property ($fell(wr) |-> $past(req))
    else $error("answer without request");
  unmapped_zero_a: assert property
    (i_av.read && !wr && i_av.address > 4'h8 |-> o_av_readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property
    (!(i_av.read && wr) |=> $stable(o_av_readdata))
    else $error("read data moved");
  reset_clear_a: assert property ($fell(i_rst) |-> wr && !hold && !shot
    && o_flip_outputs == 2'h0) else $error("outputs not cleared");
  shot_len_a: assert property ($rose(shot) |->
    (shot throughout ##SLO 1) ##[1:SWIN] !shot) else $error("pulse length");
  hold_len_a: assert property ($fell(hold) |-> hcnt >= HLO)
    else $error("hold released early");
  flip_one_a: assert property ($changed(o_flip_outputs) |->
    $countones(o_flip_outputs ^ $past(o_flip_outputs)) == 1)
    else $error("toggle changed two outputs");
endmodule
bind irr_decoder irr_decoder_chk #(
  .OSC_DIV_P(OSC_DIV_P), .SHOT_TICKS_P(SHOT_TICKS_P),
  .HOLD_TICKS_P(HOLD_TICKS_P)
) chk (.i_clock, .i_rst, .i_av, .o_av_readdata, .o_av_waitrequest,
  .o_hold_outputs, .o_oneshot_outputs, .o_flip_outputs);
`default_nettype wire

// File: tb/irr_tx_model.sv
// Transmitter model: baseband frames on the receive line
`timescale 1ns/10ps
`default_nettype none
module irr_tx_model #(
  parameter int unsigned DIV = 4
) (
  // Clock and line
  input  wire logic i_clock,
  output logic      o_line
);
  initial o_line = 1'b0;
  // Start bit, then 12 bits first at the top, idle low
  task automatic send(input logic [11:0] f);
    o_line <= 1'b1;
    repeat (16 * DIV) @(posedge i_clock);
    for (int i = 11; i >= 0; i--) begin
      o_line <= f[i];
      repeat (16 * DIV) @(posedge i_clock);
    end
    o_line <= 1'b0;
    repeat (4 * DIV) @(posedge i_clock);
  endtask
endmodule
`default_nettype wire

// File: tb/test_ir_remote_command_decoder.sv
// Self-checking bench for the remote command decoder
`timescale 1ns/10ps
`default_nettype none
module test_ir_remote_command_decoder;
  import irr_pkg::*;
  localparam int unsigned DIV = 4;
  logic        i_clock   = 1'b0;
  logic        i_rst     = 1'b1;
  irr_av_req_t av        = '0;
  logic        rx_line;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic        wreq;
  logic [5:0]  hold;
  logic [9:0]  shot;
  logic [1:0]  flip;
  int          fails     = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  always #12.5 i_clock = ~i_clock;

  irr_tx_model #(.DIV(DIV)) tx (.i_clock(i_clock), .o_line(rx_line));

  // Long hold time so that a repeated pair lands inside it
  irr_decoder #(
    .OSC_DIV_P(DIV), .SHOT_TICKS_P(20), .HOLD_TICKS_P(500)
  ) uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_remote_rx_in(rx_line),
    .i_av(av), .o_av_readdata(rdata), .o_av_waitrequest(wreq),
    .o_hold_outputs(hold), .o_oneshot_outputs(shot),
    .o_flip_outputs(flip)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    av.read       <= ~w;
    av.write      <= w;
    av.address    <= a;
    av.writedata  <= d;
    av.byteenable <= 4'hF;
    do @(posedge i_clock); while (wreq !== 1'b0);
    rd = rdata;
    av.read  <= 1'b0;
    av.write <= 1'b0;
    @(posedge i_clock);
  endtask

  // Idle past the copy window, then one frame pair
  task automatic pair(input logic [11:0] a, input logic [11:0] b);
    repeat (300) @(posedge i_clock);
    tx.send(a);
    tx.send(b);
  endtask

  task automatic t_regs();
    bus(1'b0, 4'h0, '0);
    check(rd, 32'h3);
    bus(1'b1, 4'h4, 32'hFFFF);
    bus(1'b0, 4'h4, '0);
    check(rd, 32'h0);
    bus(1'b0, 4'hC, '0);
    check(rd, 32'h0);
  endtask

  task automatic t_shot();
    logic [11:0] f;
    for (int k = 0; k < 10; k++) begin
      f = {3'b111, 1'b0, k < 6, k >= 6, 6'h20 >> (k % 6)};
      pair(f, f);
      check({22'h0, shot}, 32'h1 << k);
      bus(1'b0, 4'h4, '0);
      check(rd, 32'h40 << k);
      repeat (60) @(posedge i_clock);
      check({22'h0, shot}, 32'h0);
    end
  endtask

  task automatic t_flip();
    pair(12'hE42, 12'hE42);
    check({30'h0, flip}, 32'h1);
    pair(12'hE41, 12'hE41);
    check({30'h0, flip}, 32'h3);
    pair(12'hE42, 12'hE42);
    check({30'h0, flip}, 32'h2);
  endtask

  // Repeat pair restarts the release timer, then all six drop
  task automatic t_hold();
    pair(12'hF3F, 12'hF3F);
    check({26'h0, hold}, 32'h3F);
    tx.send(12'hF3F);
    tx.send(12'hF3F);
    repeat (1000) @(posedge i_clock);
    check({26'h0, hold}, 32'h3F);
    repeat (1100) @(posedge i_clock);
    check({26'h0, hold}, 32'h0);
  endtask

  task automatic t_reject();
    pair(12'hEA0, 12'hEA1);
    check({22'h0, shot}, 32'h0);
    pair(12'h6A0, 12'h6A0);
    check({22'h0, shot}, 32'h0);
    pair(12'hEA0, 12'hEA0);
    check({22'h0, shot}, 32'h1);
  endtask

  task automatic t_small();
    bus(1'b1, 4'h0, 32'h5);
    bus(1'b0, 4'h0, '0);
    check(rd, 32'h5);
    pair(12'hCA0, 12'hCA0);
    check({22'h0, shot}, 32'h1);
    pair(12'hAA0, 12'hAA0);
    check({22'h0, shot}, 32'h0);
    pair(12'hC50, 12'hC50);
    check({22'h0, shot}, 32'h0);
    pair(12'hD01, 12'hD01);
    check({26'h0, hold}, 32'h0);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_regs();
    t_shot();
    t_flip();
    t_hold();
    t_reject();
    t_small();
    results();
  end
endmodule
`default_nettype wire
